//--- verilog/crs_top.sv
// SMBus target with shared and per-lane register sets steered by the select register
`timescale 1ns/1ns
`default_nettype none
`include "crs_map.svh"

module crs_top (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // SMBus pins, sda open drain
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Address strap
   input wire logic [3:0] strap_address_bit_i,
   // Lane status from recovery logic
   input wire logic [crs_pkg::CRS_LANES-1:0] lane_lock_i,
   input wire logic [crs_pkg::CRS_LANES-1:0] lane_sigdet_i,
   // Lane reset controls and interrupt summaries
   output crs_pkg::crs_lane_rst_t lane_rst_o,
   output logic [crs_pkg::CRS_LANES-1:0] lane_irq_summary_o
);

   crs_pkg::crs_state_t q;
   crs_pkg::crs_state_t d;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic [6:0] dev_addr;
   logic [1:0] lane_idx;
   logic lane_en;
   logic [7:0] rd_ptr;
   logic [7:0] rd_val;
   logic [crs_pkg::CRS_LANES-1:0] irq;
   // Per-bit nets, since several drivers per bit group are legal only on nets
   wire logic [crs_pkg::CRS_LANES-1:0] core_rst_w;
   wire logic [crs_pkg::CRS_LANES-1:0] refclk_rst_w;
   wire logic [crs_pkg::CRS_LANES-1:0] osc_rst_w;

   // ----------------------------------------
   // Pin edge detection
   // ----------------------------------------
   // Pins are taken as synchronous, so one stage of history suffices
   assign scl_rise = scl_i & ~q.scl;
   assign scl_fall = ~scl_i & q.scl;
   assign start_det = scl_i & q.scl & q.sda & ~sda_i;
   assign stop_det = scl_i & q.scl & ~q.sda & sda_i;

   // Strap captured once after reset release
   assign dev_addr = `CRS_BASE_ADDR + {3'h0, q.strap}; // [RULE17]
   assign lane_idx = q.sel[1:0];
   assign lane_en = q.sel[`CRS_SEL_EN_BIT];
   assign irq = q.lock_loss | q.sig_lost;

   // Next read address: follow-on bytes of a read advance the pointer
   assign rd_ptr = (q.ph == crs_pkg::CRS_RDATA) ? 8'(q.ptr + 8'h01) : q.ptr;

   // ----------------------------------------
   // Read data mux
   // ----------------------------------------
   always_comb begin
      rd_val = 8'h00;
      if (rd_ptr == `CRS_SEL_ADDR) begin
         rd_val = `CRS_UNDEF_READ; // [RULE6]
      end else if (lane_en) begin
         // Lane index alone picks the source, broadcast or not
         if (rd_ptr == `CRS_LANE_CTRL_ADDR) begin
            rd_val = {4'h0, q.lane_ctrl[lane_idx]}; // [RULE2] [RULE4] [RULE20]
         end else if (rd_ptr == `CRS_LANE_FLAG_ADDR) begin
            rd_val = {3'h0, q.lock_loss[lane_idx], 3'h0, q.sig_lost[lane_idx]}; // [RULE20]
         end
      end else begin
         if (rd_ptr == `CRS_SH_ID_ADDR) begin
            rd_val = {q.strap, 4'h0}; // [RULE17] [RULE3]
         end else if (rd_ptr == `CRS_SH_IRQ_ADDR) begin
            rd_val = {4'h0, irq[0], irq[1], irq[2], irq[3]}; // [RULE18]
         end
      end
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      d = q;
      d.scl = scl_i;
      d.sda = sda_i;
      if (!q.strap_ok) begin
         d.strap = strap_address_bit_i;
         d.strap_ok = 1'b1;
      end

      // Register restore self-clears, since it restores its own bit too
      for (int l = 0; l < crs_pkg::CRS_LANES; l++) begin
         if (q.lane_ctrl[l][`CRS_CTRL_REGS_BIT]) begin
            d.lane_ctrl[l] = `CRS_CTRL_RESET; // [RULE12]
            d.lock_loss[l] = 1'b0;
            d.sig_lost[l] = 1'b0;
         end
      end

      // Serial target
      if (start_det) begin
         d.ph = crs_pkg::CRS_ADDR;
         d.cnt = 4'h0;
         d.oe = 1'b0;
      end else if (stop_det) begin
         d.ph = crs_pkg::CRS_IDLE;
         d.oe = 1'b0;
      end else if (q.ph != crs_pkg::CRS_IDLE) begin
         if (scl_rise) begin
            if (q.cnt < `CRS_BITS_BYTE) begin
               d.cnt = 4'(q.cnt + 4'h1);
               if (q.ph != crs_pkg::CRS_RDATA) begin
                  d.shreg = {q.shreg[6:0], sda_i};
               end
            end else if (q.cnt == `CRS_BITS_ACK && q.ph == crs_pkg::CRS_RDATA) begin
               d.nack = sda_i;
            end
         end else if (scl_fall) begin
            if (q.cnt == `CRS_BITS_BYTE) begin
               // Acknowledge slot: drive it for a matching address, command or write byte, release it for read bytes
               d.cnt = `CRS_BITS_ACK;
               unique case (q.ph)
                  crs_pkg::CRS_ADDR: begin
                     if (q.shreg[7:1] == dev_addr) begin
                        d.oe = 1'b1;
                        d.rw = q.shreg[0];
                     end else begin
                        d.ph = crs_pkg::CRS_IDLE;
                     end
                  end
                  crs_pkg::CRS_CMD: begin
                     d.ptr = q.shreg;
                     d.oe = 1'b1;
                  end
                  crs_pkg::CRS_WDATA: begin
                     d.oe = 1'b1;
                     if (q.ptr == `CRS_SEL_ADDR) begin
                        d.sel = q.shreg; // [RULE5] [RULE8] [RULE9]
                     end else if (lane_en && q.ptr == `CRS_LANE_CTRL_ADDR) begin // [RULE3]
                        for (int l = 0; l < crs_pkg::CRS_LANES; l++) begin
                           if (q.sel[`CRS_SEL_BCAST_BIT] || lane_idx == 2'(l)) begin
                              d.lane_ctrl[l] = q.shreg[3:0]; // [RULE1] [RULE4] [RULE10] [RULE20]
                           end
                        end
                     end
                     // Flag register and shared set hold only read-only bits here
                     // [RULE16] [RULE19]
                  end
                  crs_pkg::CRS_RDATA: begin
                     d.oe = 1'b0;
                  end
                  crs_pkg::CRS_IDLE: begin
                  end
               endcase
            end else if (q.cnt == `CRS_BITS_ACK) begin
               // End of acknowledge slot: advance phase, or the pointer after a write byte
               d.cnt = 4'h0;
               d.oe = 1'b0;
               unique case (q.ph)
                  crs_pkg::CRS_ADDR: begin
                     d.ph = q.rw ? crs_pkg::CRS_RDATA : crs_pkg::CRS_CMD;
                  end
                  crs_pkg::CRS_CMD: begin
                     d.ph = crs_pkg::CRS_WDATA;
                  end
                  crs_pkg::CRS_WDATA: begin
                     d.ptr = 8'(q.ptr + 8'h01);
                  end
                  crs_pkg::CRS_RDATA: begin
                     if (q.nack) begin
                        d.ph = crs_pkg::CRS_IDLE;
                     end
                  end
                  crs_pkg::CRS_IDLE: begin
                  end
               endcase
               // Load a read byte; reading the flag register clears lock loss
               if ((q.ph == crs_pkg::CRS_ADDR && q.rw) || (q.ph == crs_pkg::CRS_RDATA && !q.nack)) begin
                  d.ptr = rd_ptr;
                  d.shreg = rd_val;
                  d.oe = ~rd_val[7];
                  d.nack = 1'b0;
                  if (lane_en && rd_ptr == `CRS_LANE_FLAG_ADDR) begin
                     d.lock_loss[lane_idx] = 1'b0; // [RULE14] [RULE19]
                  end
               end
            end else if (q.ph == crs_pkg::CRS_RDATA) begin
               d.oe = ~q.shreg[6];
               d.shreg = {q.shreg[6:0], 1'b0};
            end
         end
      end

      // Flag setting last so a same-cycle event beats the clear
      for (int l = 0; l < crs_pkg::CRS_LANES; l++) begin
         if (lane_lock_i[l]) begin
            d.had_lock[l] = 1'b1;
         end else if (q.had_lock[l]) begin
            d.had_lock[l] = 1'b0;
            d.lock_loss[l] = 1'b1; // [RULE14]
         end
         if (lane_sigdet_i[l]) begin
            d.had_sig[l] = 1'b1;
         end else if (q.had_sig[l]) begin
            d.had_sig[l] = 1'b0;
            d.sig_lost[l] = 1'b1; // [RULE15]
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Open drain: only ever pull low
   assign sda_o = 1'b0;
   assign sda_oe_o = q.oe;
   assign lane_irq_summary_o = irq;

   for (genvar g = 0; g < crs_pkg::CRS_LANES; g++) begin : g_lane
      assign core_rst_w[g] = q.lane_ctrl[g][`CRS_CTRL_CORE_BIT]; // [RULE11]
      assign refclk_rst_w[g] = q.lane_ctrl[g][`CRS_CTRL_REFCLK_BIT]; // [RULE13]
      assign osc_rst_w[g] = q.lane_ctrl[g][`CRS_CTRL_OSC_BIT]; // [RULE13]
   end

   // One driver for the whole output struct
   assign lane_rst_o = {core_rst_w, refclk_rst_w, osc_rst_w};

endmodule // crs_top

`default_nettype wire

//--- pkg/crs_map.svh
// Register map, field positions and reset values of the lane register select block
//
// Behaviour
// [RULE1] Broadcast bit with enable writes all lanes
// [RULE2] Lane reads come from lane index field
// [RULE3] Lane sets reached only while enable set
// [RULE4] Low addresses hit selected lane when enabled
// [RULE5] Writes to 0xff always update select register
// [RULE6] Select register reads return undefined value
// [RULE7] Host writes full select byte, upper zero
// [RULE8] Valid select codes map shared, lane, broadcast
// [RULE9] Selection persists until select register rewritten
// [RULE10] Four independent lane register sets exist
// [RULE11] Lane ctrl bit 3 holds core reset
// [RULE12] Lane ctrl bit 2 restores lane defaults
// [RULE13] Bits 1,0 reset refclk, divider domains
// [RULE14] Lock loss flag sets, clears on read
// [RULE15] Signal lost flag sets after signal lost
// [RULE16] Writes to read-only bits are ignored
// [RULE17] Target address is 0x18 plus strap
// [RULE18] Shared reg 5 holds lane summaries
// [RULE19] Flags clear only by reading their register; code clears only lock loss on read, and lane ctrl bit 2 clears both flags
// [RULE20] Reserved lane bits read zero, writes ignored
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// ----------------------------------------
// Addresses
// ----------------------------------------
`define CRS_SEL_ADDR 8'hff
`define CRS_LANE_CTRL_ADDR 8'h00
`define CRS_LANE_FLAG_ADDR 8'h01
`define CRS_SH_ID_ADDR 8'h00
`define CRS_SH_IRQ_ADDR 8'h05
`define CRS_BASE_ADDR 7'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRS_SEL_BCAST_BIT 3
`define CRS_SEL_EN_BIT 2
`define CRS_CTRL_CORE_BIT 3
`define CRS_CTRL_REGS_BIT 2
`define CRS_CTRL_REFCLK_BIT 1
`define CRS_CTRL_OSC_BIT 0

// ----------------------------------------
// Reset values and bit counts
// ----------------------------------------
`define CRS_SEL_RESET 8'h00
`define CRS_CTRL_RESET 4'h0
`define CRS_UNDEF_READ 8'h00
`define CRS_BITS_BYTE 4'h8
`define CRS_BITS_ACK 4'h9

`endif

//--- pkg/crs_pkg.sv
// Types shared by the lane register select block
package crs_pkg;

   localparam int CRS_LANES = 4;

   // Serial target phase
   typedef enum logic [2:0] {
      CRS_IDLE,
      CRS_ADDR,
      CRS_CMD,
      CRS_WDATA,
      CRS_RDATA
   } crs_phase_t;

   // Whole state of the block
   typedef struct packed {
      crs_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic rw;
      logic nack;
      logic oe;
      logic [7:0] ptr;
      logic [7:0] sel;
      logic scl;
      logic sda;
      logic [3:0] strap;
      logic strap_ok;
      logic [CRS_LANES-1:0][3:0] lane_ctrl;
      logic [CRS_LANES-1:0] had_lock;
      logic [CRS_LANES-1:0] had_sig;
      logic [CRS_LANES-1:0] lock_loss;
      logic [CRS_LANES-1:0] sig_lost;
   } crs_state_t;

   // Per-lane reset controls driven out
   typedef struct packed {
      logic [CRS_LANES-1:0] core;
      logic [CRS_LANES-1:0] refclk;
      logic [CRS_LANES-1:0] osc;
   } crs_lane_rst_t;

endpackage

//--- test/crs_properties.sv
// Port-level assertion checker for the lane register select block
`timescale 1ns/1ns
`default_nettype none
module crs_properties (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   // SMBus pins
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   // Strap and lane status
   input wire logic [3:0] strap_address_bit_i,
   input wire logic [crs_pkg::CRS_LANES-1:0] lane_lock_i,
   input wire logic [crs_pkg::CRS_LANES-1:0] lane_sigdet_i,
   // Lane outputs
   input wire crs_pkg::crs_lane_rst_t lane_rst_o,
   input wire logic [crs_pkg::CRS_LANES-1:0] lane_irq_summary_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // Data pin may only pull low
   a_sda_open_drain: assert property (sda_o == 1'b0)
      else $error("sda driven high");
   // Device starts driving only while the host holds the clock low
   a_drive_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i && !$past(scl_i))
      else $error("sda drive began with scl high");
   a_oe_steady_high: assert property ($rose(scl_i) |-> $stable(sda_oe_o) [*2])
      else $error("sda drive moved during scl high");
   // Everything quiet straight out of reset
   a_reset_quiet: assert property ($rose(reset_n_i) |-> !sda_oe_o && lane_rst_o == '0 && lane_irq_summary_o == '0)
      else $error("outputs not at defaults after reset");
   // Lane control updates only land in acknowledge slots, never with scl high
   a_ctrl_scl_high: assert property (scl_i && $past(scl_i) |-> $stable(lane_rst_o))
      else $error("lane reset outputs moved during scl high");
   a_sig_loss_irq: assert property ($fell(lane_sigdet_i[0]) |-> ##[1:3] lane_irq_summary_o[0])
      else $error("signal loss not flagged");
   a_lock_loss_irq: assert property ($fell(lane_lock_i[1]) |-> ##[1:3] lane_irq_summary_o[1])
      else $error("lock loss not flagged");
   a_irq_held_high: assert property (scl_i && $past(scl_i) |-> ($past(lane_irq_summary_o) & ~lane_irq_summary_o) == '0)
      else $error("flag cleared outside a read");
   // Main scenarios reached
   c_ack_drive: cover property ($rose(sda_oe_o));
   c_core_reset: cover property ($rose(lane_rst_o.core[0]));
   c_flag_clear: cover property ($fell(lane_irq_summary_o[1]));
endmodule // crs_properties
bind crs_top crs_properties crs_properties_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
   .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .strap_address_bit_i(strap_address_bit_i),
   .lane_lock_i(lane_lock_i), .lane_sigdet_i(lane_sigdet_i), .lane_rst_o(lane_rst_o),
   .lane_irq_summary_o(lane_irq_summary_o));
`default_nettype wire

//--- test/crs_host.sv
// Behavioural SMBus host driving the block's serial pins
`timescale 1ns/1ns
`default_nettype none
module crs_host (
   // Clock
   input wire logic clk_i,
   // Resolved data wire
   input wire logic sda_i,
   // Host drive, pull high means data pulled low
   output logic scl_o,
   output logic sda_pull_o
);
   initial begin
      scl_o = 1'b1;
      sda_pull_o = 1'b0;
   end
   // Wait whole cycles, landing just after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Start or repeated start; data moves only mid low phase to avoid false framing
   task automatic start();
      cyc(2);
      sda_pull_o = 1'b0;
      cyc(2);
      scl_o = 1'b1;
      cyc(4);
      sda_pull_o = 1'b1;
      cyc(4);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      cyc(2);
      sda_pull_o = 1'b1;
      cyc(2);
      scl_o = 1'b1;
      cyc(4);
      sda_pull_o = 1'b0;
      cyc(4);
   endtask
   // One bit: set while low, sample at end of high phase
   task automatic bit_x(input logic b, output logic r);
      cyc(2);
      sda_pull_o = !b;
      cyc(2);
      scl_o = 1'b1;
      cyc(4);
      r = sda_i;
      scl_o = 1'b0;
   endtask
   // Whole byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic nak);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ack, nak);
   endtask
endmodule // crs_host
`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the lane register select block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam logic [3:0] STRAP = 4'h5;
   localparam logic [6:0] DEV = 7'h18 + {3'h0, STRAP};
   logic ref_clk_i, reset_n_i, scl, pull, sda_o, sda_oe, nak, nk;
   logic [3:0] lock, sigdet, irq;
   logic [7:0] q;
   crs_pkg::crs_lane_rst_t lrst;
   int mismatches, total_checks;
   wire logic sda_line;
   // Pull-up wire: low when either party pulls
   assign sda_line = !pull && !(sda_oe && !sda_o);
   crs_top crs_top_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .strap_address_bit_i(STRAP), .lane_lock_i(lock),
      .lane_sigdet_i(sigdet), .lane_rst_o(lrst), .lane_irq_summary_o(irq));
   crs_host crs_host_inst (.clk_i(ref_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));
   task automatic chk_bits(input string n, input logic [11:0] e, input logic [11:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      chk_bits(n, {4'h0, e}, {4'h0, g});
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Register write and read frames; a missing acknowledge is flagged in write frames only
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      crs_host_inst.start();
      crs_host_inst.xfer({DEV, 1'b0}, 1'b1, q, nak);
      crs_host_inst.xfer(a, 1'b1, q, nk);
      nak = nak | nk;
      crs_host_inst.xfer(d, 1'b1, q, nk);
      crs_host_inst.stop();
      chk_bits("wack", 12'h0, {11'h0, nak | nk});
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      crs_host_inst.start();
      crs_host_inst.xfer({DEV, 1'b0}, 1'b1, q, nak);
      crs_host_inst.xfer(a, 1'b1, q, nk);
      crs_host_inst.start();
      crs_host_inst.xfer({DEV, 1'b1}, 1'b1, q, nk);
      crs_host_inst.xfer(8'hff, 1'b1, d, nk);
      crs_host_inst.stop();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_idle();
      chk_bits("rst", 12'h0, lrst);
      rd(8'h00, q);
      chk_byte("id", {STRAP, 4'h0}, q);
      // Neighbouring address must be ignored
      crs_host_inst.start();
      crs_host_inst.xfer({DEV + 7'h1, 1'b0}, 1'b1, q, nak);
      crs_host_inst.stop();
      chk_bits("nak", 12'h1, {11'h0, nak});
   endtask
   task automatic t_lanes();
      logic [11:0] e;
      e = 12'h0;
      for (int k = 0; k < 4; k++) begin
         wr(8'hff, 8'h04 | k[7:0]);
         wr(8'h00, 8'hfb);
         e = e | (12'h111 << k);
         chk_bits("rst", e, lrst);
         rd(8'h00, q);
         chk_byte("ctl", 8'h0b, q);
      end
      wr(8'hff, 8'h00);
      wr(8'h00, 8'h00);
      chk_bits("rst", e, lrst);
   endtask
   task automatic t_bcast();
      wr(8'hff, 8'h0e);
      wr(8'h00, 8'h08);
      chk_bits("rst", 12'hf00, lrst);
      wr(8'hff, 8'h04);
      wr(8'h00, 8'h09);
      wr(8'hff, 8'h0d);
      rd(8'hff, q); // Value undefined, only the side effects matter
      rd(8'h00, q);
      chk_byte("ctl", 8'h08, q);
      wr(8'hff, 8'h0c);
      rd(8'h00, q);
      chk_byte("ctl", 8'h09, q);
   endtask
   task automatic t_flags();
      wr(8'hff, 8'h04);
      lock = 4'hc;
      sigdet = 4'he;
      rd(8'h01, q);
      chk_byte("flag", 8'h11, q);
      chk_bits("irq", 12'h3, {8'h0, irq});
      rd(8'h01, q);
      chk_byte("flag", 8'h01, q);
      wr(8'h01, 8'hff);
      rd(8'h01, q);
      chk_byte("flag", 8'h01, q);
      wr(8'hff, 8'h0c);
      wr(8'h01, 8'h00);
      wr(8'hff, 8'h05);
      rd(8'h01, q);
      chk_byte("flag", 8'h10, q);
      wr(8'hff, 8'h00);
      rd(8'h05, q);
      chk_byte("sum", 8'h08, q);
      wr(8'hff, 8'h04);
      wr(8'h00, 8'h04);
      rd(8'h01, q);
      chk_byte("flag", 8'h00, q);
      chk_bits("rst", 12'he00, lrst);
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Watchdog, about six times the expected run
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      reset_n_i = 1'b0;
      lock = 4'hf;
      sigdet = 4'hf;
      mismatches = 0;
      total_checks = 0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      reset_n_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
      t_idle();
      t_lanes();
      t_bcast();
      t_flags();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
